// [design/dpsl_pkg.sv]
// Package for the serial latch control of a multi-channel digital potentiometer.
// Assumes every pin input is synchronised to clk_sys before any logic reads it.
package dpsl_pkg;

   // Word layout: address field on top, data field below.
   localparam int WORD_BITS        = 11;
   localparam int ADDR_BITS        = 3;
   localparam int DATA_BITS        = 8;
   localparam int ADDR_LSB         = 8;
   localparam int WORD_MSB         = 10;
   localparam int DEFAULT_CHANNELS = 4;
   localparam int SYNC_STAGES      = 2;

   // Values after reset; MIDSCALE is also the wiper value after a preset.
   localparam logic [DATA_BITS-1:0] MIDSCALE    = 8'h80;
   localparam logic [WORD_BITS-1:0] SHIFT_RESET = 11'h000;
   localparam logic                 SDO_RESET   = 1'b1;

   // Pin bundle as seen by the block, in the order of the packed fields.
   typedef struct packed {
      logic sclk;
      logic csN;
      logic serial_in;
      logic presetN;
      logic shutdownN;
   } dpsl_pins_t;

   // Idle levels of the pins, loaded into the synchroniser under reset.
   localparam dpsl_pins_t PINS_IDLE = 5'h0B;

   // Frame tracking: chip select low means a frame is open.
   typedef enum logic [0:0] {
      FRM_IDLE,
      FRM_ACTIVE
   } dpsl_frame_t;

endpackage : dpsl_pkg

// [design/dpsl_sync.sv]
// Multi-bit two-flop synchroniser for asynchronous pin inputs.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/1ps
module dpsl_sync
   import dpsl_pkg::*;
#(
   parameter int                WIDTH     = 5,
   parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   // One pair of flops per bit; the first stage feeds only the second.
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            stage1[b] <= RESET_VAL[b];
            dout[b]   <= RESET_VAL[b];
         end else begin
            stage1[b] <= din[b];
            dout[b]   <= stage1[b];
         end
      end
   end

endmodule : dpsl_sync

// [design/dpsl_digipot.sv]
// Serial input, address decode and wiper latches of a multi-channel digital potentiometer.
// Assumes all pins are asynchronous to clk_sys and change slower than a few clk_sys cycles.
// Summary of operation
// - Shift serial_in on serial clock rise, select low.
// - serial_out shows bit entered eleven shifts earlier.
// - Clock low holds register, serial_out enabled.
// - Select rising edge loads addressed wiper latch.
// - Only the last eleven shifted bits kept.
// - Exactly one latch enabled per valid address.
// - Latch takes the final eight data bits.
// - Preset low forces midscale, clears output latch.
// - Preset rise with select high loads 0x80.
// - Shutdown opens A terminals, releases serial_out.
// - serial_out is open drain, pulls low only.
// - Power-up sets every wiper latch to midscale.
// - Shutdown keeps all wiper latch contents.
`timescale 1ns/1ps
module dpsl_digipot
   import dpsl_pkg::*;
#(
   parameter int NUM_CHANNELS = DEFAULT_CHANNELS
) (
   input  wire logic                                clk_sys,
   input  wire logic                                rst,
   input  wire logic                                serialClk,
   input  wire logic                                chipSelectN,
   input  wire logic                                serialIn,
   input  wire logic                                presetN,
   input  wire logic                                shutdownN,
   output      logic                                serialOut,
   output      logic                                serialOutOe,
   output      logic [NUM_CHANNELS-1:0][DATA_BITS-1:0] wiperLatch,
   output      logic                                terminalAOpen,
   output      logic                                wiperToB
);

   dpsl_pins_t                              rawPins;
   dpsl_pins_t                              syncPins;
   dpsl_pins_t                              prevPins;
   dpsl_frame_t                             frame;
   dpsl_frame_t                             next_frame;
   logic [WORD_BITS-1:0]                    shiftReg;
   logic [WORD_BITS-1:0]                    next_shiftReg;
   logic                                    sdoLatch;
   logic                                    next_sdoLatch;
   logic [NUM_CHANNELS-1:0][DATA_BITS-1:0]  next_wiperLatch;
   logic                                    next_serialOutOe;
   logic                                    next_terminalAOpen;
   logic                                    next_wiperToB;
   logic                                    sclkRise;
   logic                                    csRise;
   logic                                    presetRise;
   logic                                    csLow;
   logic [ADDR_BITS-1:0]                    addrField;
   logic [DATA_BITS-1:0]                    dataField;
   logic                                    addrValid;
   logic [NUM_CHANNELS-1:0]                 loadEn;

   // Latency through the block, counted in clk_sys edges after a pin changes:
   // edge one takes the pin into the first flop, edge two makes it visible to
   // the logic, and edge three updates the shift register, the output latch
   // or the addressed wiper latch. The pad drive follows a change of the output latch one edge later.
   // A serial clock level therefore has to last at least three system clock
   // cycles, and serial data has to stand that long around each rising edge.
   // The host slows its link clock to meet this; in exchange no part of the
   // link runs in a clock domain of its own, and nothing crosses domains
   // except through the two-flop synchroniser below.
   // Preset low wins over a select rise in the same cycle, and a preset
   // release with select high wins as well, so a load can be lost only while
   // the host is itself forcing midscale.

   // Gather the pins so one synchroniser instance covers them all.
   assign rawPins = '{sclk: serialClk, csN: chipSelectN, serial_in: serialIn,
                      presetN: presetN, shutdownN: shutdownN};

   dpsl_sync #(
      .WIDTH     ($bits(dpsl_pins_t)),
      .RESET_VAL (PINS_IDLE)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (rawPins),
      .dout    (syncPins)
   );

   // Edge detection works on synchronised levels only, so serial data and
   // clock keep their relative timing through the same two-flop delay.
   assign sclkRise   = syncPins.sclk & ~prevPins.sclk;
   assign presetRise = syncPins.presetN & ~prevPins.presetN;
   assign csLow      = ~syncPins.csN;
   assign csRise     = (frame == FRM_ACTIVE) & syncPins.csN;

   // Address field in the top three bits, data field in the low eight.
   assign addrField = shiftReg[WORD_MSB -: ADDR_BITS];
   assign dataField = shiftReg[DATA_BITS-1:0];
   assign addrValid = (addrField < ADDR_BITS'(NUM_CHANNELS));

   for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_dec
      assign loadEn[i] = csRise & syncPins.presetN & (addrField == ADDR_BITS'(i));
   end

   // Next-state logic for the frame, shift register, output latch and wipers.
   always_comb begin
      next_frame      = csLow ? FRM_ACTIVE : FRM_IDLE;
      next_shiftReg   = shiftReg;
      next_sdoLatch   = sdoLatch;
      next_wiperLatch = wiperLatch;
      // shift on clock rise; hold without an edge.
      if (csLow && sclkRise) begin
         // oldest bit falls out, only eleven remain.
         next_shiftReg = {shiftReg[WORD_MSB-1:0], syncPins.serial_in};
         // eleventh earlier bit moves to the output latch.
         next_sdoLatch = shiftReg[WORD_MSB];
      end
      if (!syncPins.presetN) begin
         // preset forces midscale and clears output latch.
         next_wiperLatch = {NUM_CHANNELS{MIDSCALE}};
         next_sdoLatch   = 1'b0;
      end else if (presetRise && syncPins.csN) begin
         next_wiperLatch = {NUM_CHANNELS{MIDSCALE}};
      end else begin
         // load data field on select rise; bad address ignored.
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (loadEn[i]) begin
               next_wiperLatch[i] = dataField;
            end
         end
      end
   end

   // Pin drive: the pad is released during shutdown to save pull-up power.
   always_comb begin
      // enable only in a frame and not in shutdown.
      next_serialOutOe   = csLow & syncPins.shutdownN & ~sdoLatch;
      next_terminalAOpen = ~syncPins.shutdownN;
      next_wiperToB      = ~syncPins.shutdownN;
   end

   assign serialOut = 1'b0;

   // Core state registers; wipers start at midscale. shutdown
   // does not touch the wipers, so settings return when it ends.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         frame         <= FRM_IDLE;
         prevPins      <= PINS_IDLE;
         shiftReg      <= SHIFT_RESET;
         sdoLatch      <= SDO_RESET;
         wiperLatch    <= {NUM_CHANNELS{MIDSCALE}};
      end else begin
         frame         <= next_frame;
         prevPins      <= syncPins;
         shiftReg      <= next_shiftReg;
         sdoLatch      <= next_sdoLatch;
         wiperLatch    <= next_wiperLatch;
      end
   end

   // Pin drive registers; the pad starts released, the A terminal switch closed and the wiper-to-B switch open.
   // Keeping them in flops avoids glitches on the pad while pins resolve.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         serialOutOe   <= 1'b0;
         terminalAOpen <= 1'b0;
         wiperToB      <= 1'b0;
      end else begin
         serialOutOe   <= next_serialOutOe;
         terminalAOpen <= next_terminalAOpen;
         wiperToB      <= next_wiperToB;
      end
   end

   // Checks on the behaviour above.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_shift_on_edge: assert property (
      (csLow && sclkRise) |=> shiftReg == {$past(shiftReg[WORD_MSB-1:0]), $past(syncPins.serial_in)})
      else $error("shift register did not take serial input");

   a_sdo_delay_line: assert property (
      (csLow && sclkRise && syncPins.presetN) |=> sdoLatch == $past(shiftReg[WORD_MSB]))
      else $error("output latch not fed from last stage");

   a_hold_no_edge: assert property (
      (!sclkRise) |=> $stable(shiftReg))
      else $error("shift register changed without a clock edge");

   a_sdo_enabled: assert property (
      (csLow && syncPins.shutdownN && !sdoLatch) |=> serialOutOe)
      else $error("serial output not enabled in frame");

   a_load_latch: assert property (
      (csRise && syncPins.presetN && addrValid && !presetRise) |=>
         wiperLatch[$past(addrField)] == $past(dataField))
      else $error("addressed latch not loaded with data field");

   a_one_latch_only: assert property (
      (csRise && syncPins.presetN && addrValid) |-> $onehot(loadEn))
      else $error("latch enable not one-hot");

   a_no_stray_enable: assert property (
      !csRise |-> loadEn == '0)
      else $error("latch enabled outside select rise");

   a_bad_addr_keep: assert property (
      (csRise && syncPins.presetN && !addrValid && !presetRise) |=> $stable(wiperLatch))
      else $error("invalid address altered a latch");

   a_preset_mid: assert property (
      !syncPins.presetN |=> (wiperLatch == {NUM_CHANNELS{MIDSCALE}}) && !sdoLatch)
      else $error("preset did not force midscale");

   a_preset_rise: assert property (
      (presetRise && syncPins.csN) |=> wiperLatch == {NUM_CHANNELS{MIDSCALE}})
      else $error("preset release did not load midscale");

   a_shutdown_pins: assert property (
      !syncPins.shutdownN |=> !serialOutOe && terminalAOpen && wiperToB)
      else $error("shutdown did not release pins");

   a_shutdown_keep: assert property (
      (!syncPins.shutdownN && syncPins.presetN && !csRise && !presetRise)
         |=> $stable(wiperLatch))
      else $error("shutdown disturbed wiper latches");

   a_idle_no_shift: assert property (
      (!csLow) |=> $stable(shiftReg))
      else $error("shift register moved outside a frame");

   a_shift_lsb_in: assert property (
      (csLow && sclkRise) |=> shiftReg[0] == $past(syncPins.serial_in))
      else $error("serial input bit not taken at the bottom");

   a_oldest_dropped: assert property (
      (csLow && sclkRise) |=> shiftReg[WORD_MSB:1] == $past(shiftReg[WORD_MSB-1:0]))
      else $error("shift register bits did not move up by one");

   a_oe_off_idle: assert property (
      (!csLow) |=> !serialOutOe)
      else $error("serial output driven outside a frame");

   a_oe_follows_latch: assert property (
      (csLow && syncPins.shutdownN && sdoLatch) |=> !serialOutOe)
      else $error("serial output pulled low for a one bit");

   a_sdo_hold_idle: assert property (
      (!sclkRise && syncPins.presetN) |=> $stable(sdoLatch))
      else $error("output latch changed without a clock edge");

   a_frame_tracks: assert property (
      csLow |=> frame == FRM_ACTIVE)
      else $error("frame not open while select is low");

   a_frame_closes: assert property (
      (!csLow) |=> frame == FRM_IDLE)
      else $error("frame still open after select rose");

   a_rise_needs_frame: assert property (
      csRise |-> $past(csLow))
      else $error("select rise seen without an open frame");

   a_wiper_hold_idle: assert property (
      (!csRise && syncPins.presetN && !presetRise) |=> $stable(wiperLatch))
      else $error("wiper latch changed without a load");

   a_bad_addr_no_enable: assert property (
      (!addrValid) |-> loadEn == '0)
      else $error("unimplemented address enabled a latch");

   a_preset_drops_load: assert property (
      (!syncPins.presetN) |-> loadEn == '0)
      else $error("latch enabled while preset held");

   a_tob_matches: assert property (
      wiperToB == terminalAOpen)
      else $error("wiper to B switch differs from A terminal switch");

   a_run_closes_a: assert property (
      syncPins.shutdownN |=> !terminalAOpen && !wiperToB)
      else $error("terminals left in shutdown state while running");

   a_sdo_never_high: assert property (
      serialOut == 1'b0)
      else $error("serial output drove a high level");

   c_word_loaded: cover property (csRise && addrValid ##1 1'b1);
   c_bad_addr:    cover property (csRise && !addrValid);
   c_preset:      cover property (!syncPins.presetN ##1 presetRise);
   c_shutdown:    cover property (!syncPins.shutdownN [*4] ##1 syncPins.shutdownN);
   c_chain_low:   cover property (csLow && sclkRise && !sdoLatch);

endmodule : dpsl_digipot

// [dv/dpsl_host_model.sv]
// Host model that drives the three-wire serial link into the potentiometer block.
// Assumes the bench resolves the open-drain output with a pull-up and feeds it back.
`timescale 1ns/1ps
module dpsl_host_model
   import dpsl_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sdoPin,
   output      logic        serialClk,
   output      logic        chipSelectN,
   output      logic        serialIn,
   output      logic [21:0] seenBits
);
   localparam int HALF = 5;

   // Idle pin levels; the link clock stands still outside frames.
   initial begin
      serialClk   = 1'b0;
      chipSelectN = 1'b1;
      serialIn    = 1'b1;
      seenBits    = 22'h000000;
   end

   // Changes the select line and lets it settle for half a link period.
   task automatic set_select(input logic level);
      chipSelectN <= level;
      repeat (HALF) @(posedge clk_sys);
   endtask : set_select

   task automatic send_bits(input logic [21:0] bits, input int n);
      set_select(1'b0);
      for (int i = n - 1; i >= 0; i--) begin
         serialIn <= bits[i];
         repeat (HALF) @(posedge clk_sys);
         serialClk <= 1'b1;
         repeat (HALF) @(posedge clk_sys);
         serialClk <= 1'b0;
         seenBits  <= {seenBits[20:0], sdoPin};  // Sampled two cycles after the shift settles.
      end
      // A released data line shows the inverse so a stale value cannot pass.
      serialIn <= ~bits[0];
      set_select(1'b1);
   endtask : send_bits
endmodule : dpsl_host_model

// [dv/tb_top.sv]
// Self-checking bench for the serial latch control of the potentiometer block.
// Assumes a four-channel build and the host model beside it on the serial link.
`timescale 1ns/1ps
module tb_top
   import dpsl_pkg::*;
;
   logic                          clk_sys;
   logic                          rst;
   logic                          presetN;
   logic                          shutdownN;
   logic                          serialClk;
   logic                          chipSelectN;
   logic                          serialIn;
   logic                          serialOut;
   logic                          serialOutOe;
   logic                          terminalAOpen;
   logic                          wiperToB;
   logic                          sdoPin;
   logic [21:0]                   seenBits;
   logic [3:0][DATA_BITS-1:0]     wipers;
   logic [DATA_BITS-1:0]          expW [4];
   int                            fails;
   int                            num_checks;

   assign sdoPin = serialOutOe ? serialOut : 1'b1;

   dpsl_digipot #(.NUM_CHANNELS(4)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .serialClk(serialClk), .chipSelectN(chipSelectN),
      .serialIn(serialIn), .presetN(presetN), .shutdownN(shutdownN),
      .serialOut(serialOut), .serialOutOe(serialOutOe), .wiperLatch(wipers),
      .terminalAOpen(terminalAOpen), .wiperToB(wiperToB));

   dpsl_host_model hostU (
      .clk_sys(clk_sys), .sdoPin(sdoPin), .serialClk(serialClk),
      .chipSelectN(chipSelectN), .serialIn(serialIn), .seenBits(seenBits));

   // The 125 MHz system clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Prints the verdict and ends the run; shared with the watchdog.
   task automatic tally_and_finish;
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [WORD_BITS-1:0] seen, input logic [WORD_BITS-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Compares every wiper latch with the expected table.
   task automatic check_all;
      for (int c = 0; c < 4; c++) begin
         check(WORD_BITS'(wipers[c]), WORD_BITS'(expW[c]));
      end
   endtask : check_all

   // Waits a few cycles so that synchronised pin changes reach the outputs.
   task automatic settle;
      repeat (6) @(posedge clk_sys);
   endtask : settle

   // A hang of the link is cut short well after the tests should be done.
   initial begin
      repeat (8000) @(posedge clk_sys);
      fails++;
      tally_and_finish;
   end

   // Main sequence of scenarios.
   initial begin
      fails = 0;
      num_checks = 0;
      rst = 1'b1;
      presetN = 1'b1;
      shutdownN = 1'b1;
      expW = '{8'h80, 8'h80, 8'h80, 8'h80};
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      settle;
      check_all;
      expW = '{8'h01, 8'hFE, 8'h5A, 8'hC3};
      for (int c = 0; c < 4; c++) begin
         hostU.send_bits({11'h000, 3'(c), expW[c]}, 11);
      end
      check_all;
      // Fourteen bits: the three oldest fall off the top.
      hostU.send_bits({8'h00, 3'b111, 3'h1, 8'h66}, 14);
      expW[1] = 8'h66;
      check_all;
      for (int a = 4; a < 8; a++) begin
         hostU.send_bits({11'h000, 3'(a), 8'hFF}, 11);
      end
      check_all;
      // Two chained words: the first comes out of the chain output as it is pushed on.
      hostU.send_bits({3'h2, 8'h99, 3'h3, 8'h24}, 22);
      expW[3] = 8'h24;
      check_all;
      check(seenBits[10:0], 11'h299);
      shutdownN <= 1'b0;
      settle;
      check(WORD_BITS'({serialOutOe, terminalAOpen, wiperToB}), 11'h003);
      shutdownN <= 1'b1;
      settle;
      check_all;
      hostU.set_select(1'b0);
      presetN <= 1'b0;
      settle;
      expW = '{8'h80, 8'h80, 8'h80, 8'h80};
      check_all;
      check(WORD_BITS'({serialOutOe, serialOut}), 11'h002);
      repeat (20) @(posedge clk_sys);
      check(WORD_BITS'(serialOutOe), 11'h001);
      shutdownN <= 1'b0;
      settle;
      check(WORD_BITS'(serialOutOe), 11'h000);
      shutdownN <= 1'b1;
      hostU.set_select(1'b1);
      presetN <= 1'b1;
      settle;
      check_all;
      tally_and_finish;
   end
endmodule : tb_top
